/* File: design/nandec_pkg.sv */
package nandec_pkg;
  // feature addresses and bit fields
  localparam logic [7:0] FEAT_ECC_ADDR = 8'hB0;
  localparam logic [7:0] FEAT_STAT_ADDR = 8'hC0;
  localparam int ECC_EN_BIT = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ECC_LSB = 4;
  // page layout
  localparam int PAGE_BYTES = 2112;
  localparam logic [11:0] PAGE_LAST = 12'h83F;
  localparam logic [9:0] SECT_MAIN = 10'h200;
  localparam logic [9:0] SECT_LAST = 10'h203;
  localparam logic [11:0] META_BASE = 12'h804;
  localparam logic [11:0] CHK_BASE = 12'h808;
  localparam logic [11:0] CHK_END = 12'h80F;
  localparam logic [11:0] BAD_MARK_ADDR = 12'h800;
  localparam logic [7:0] BAD_MARK = 8'h00;
  localparam logic [2:0] CHK_LAST = 3'h7;
  localparam logic [10:0] POS_MAX = 11'h408;
  // correction result codes
  localparam logic [1:0] ECC_NONE = 2'h0;
  localparam logic [1:0] ECC_FIXED = 2'h1;
  localparam logic [1:0] ECC_FAIL = 2'h2;
  // reset busy time
  localparam int T_RST_MS = 32'h0000_0001;
  localparam int CLK_KHZ = 32'h0000_9C40;
  localparam int RST_CYC = T_RST_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RST = 3'b001,
    S_LOAD = 3'b010,
    S_SCAN = 3'b011,
    S_CHK = 3'b100,
    S_FIX = 3'b101,
    S_WRITE = 3'b110
  } nandec_state_t;

  typedef struct packed {
    logic we;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } nandec_feat_t;

  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] data;
  } nandec_load_t;
endpackage

/* File: design/nandec_lane.sv */
`timescale 1ns/1ps
module nandec_lane (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic clr,
  input wire logic bit_lo,
  input wire logic bit_hi,
  input wire logic [9:0] idx,
  output logic [11:0] code
);
  logic [11:0] acc_ff;
  logic [11:0] nxt_acc;
  logic [10:0] p_lo;
  logic [10:0] p_hi;

  // position-xor plus parity over one bit lane
  always_comb begin
    p_lo = 11'({idx, 1'b0} + 11'h001);
    p_hi = 11'({idx, 1'b0} + 11'h002);
    nxt_acc = clr ? 12'h000 : acc_ff;
    if (en) begin
      if (bit_lo) begin
        nxt_acc = nxt_acc ^ {1'b1, p_lo};
      end
      if (bit_hi) begin
        nxt_acc = nxt_acc ^ {1'b1, p_hi};
      end
    end
  end

  always_ff @(posedge clk) begin
    acc_ff <= rst ? 12'h000 : nxt_acc;
  end

  assign code = acc_ff;
endmodule

/* File: design/nandec_top.sv */
`timescale 1ns/1ps
module nandec_top #(
  parameter int RST_CYCLES = nandec_pkg::RST_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PWR_OK,
  input wire logic WP_N,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic RESET_GO,
  input wire logic PROG_GO,
  input wire logic READ_GO,
  input wire logic MARK_GO,
  input wire logic SO_START,
  input wire logic [11:0] SO_COL,
  input wire nandec_pkg::nandec_feat_t FEAT,
  input wire nandec_pkg::nandec_load_t LOAD,
  input wire logic ARR_RVALID,
  input wire logic [7:0] ARR_RDATA,
  output logic ARR_WVALID,
  output logic [7:0] ARR_WDATA,
  output logic [7:0] FEAT_RDATA,
  output logic BUSY,
  output logic ECC_EN,
  output logic SO,
  output logic SO_OE_N
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [3:0] sy1_ff;
  logic [3:0] sy2_ff;
  logic [3:0] sy3_ff;
  always_ff @(posedge CLK) begin
    sy1_ff <= {PWR_OK, WP_N, SCK, CS_N};
    sy2_ff <= sy1_ff;
    sy3_ff <= sy2_ff;
  end
  logic pwr_ok;
  logic wp_rise;
  logic sck_fall;
  logic cs_low;
  assign pwr_ok = sy2_ff[3];
  assign wp_rise = sy2_ff[2] & ~sy3_ff[2];
  assign sck_fall = ~sy2_ff[1] & sy3_ff[1];
  assign cs_low = ~sy2_ff[0];

  ////////////////////////////////////////////////////////////////////////
  // cache register and sector address map
  logic [7:0] cache [0:nandec_pkg::PAGE_BYTES-1];

  function automatic logic [11:0] addr_of(input logic [1:0] s,
                                          input logic [9:0] k);
    logic [11:0] a;
    if (k < nandec_pkg::SECT_MAIN) begin
      a = {1'b0, s, k[8:0]};
    end else begin
      a = 12'(nandec_pkg::META_BASE + {6'h00, s, 4'h0} +
              {2'h0, k - nandec_pkg::SECT_MAIN});
    end
    return a;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  nandec_pkg::nandec_state_t st_ff, nxt_st;
  logic [31:0] cnt_ff, nxt_cnt;
  logic [11:0] ptr_ff, nxt_ptr;
  logic [9:0] k_ff, nxt_k;
  logic [2:0] j_ff, nxt_j;
  logic [1:0] sec_ff, nxt_sec;
  logic [1:0] lane_ff, nxt_lane;
  logic rd_ff, nxt_rd;
  logic mark_ff, nxt_mark;
  logic ecc_en_ff, nxt_ecc_en;
  logic [1:0] ecc_st_ff, nxt_ecc_st;
  logic cor_ff, nxt_cor;
  logic unc_ff, nxt_unc;
  logic por_done_ff, nxt_por_done;
  logic [63:0] stored_ff, nxt_stored;
  logic wv_ff, nxt_wv;
  logic [7:0] wd_ff, nxt_wd;
  logic [7:0] frd_ff, nxt_frd;
  logic [11:0] col_ff, nxt_col;
  logic [7:0] sh_ff, nxt_sh;
  logic [2:0] bc_ff, nxt_bc;
  logic oe_n_ff, nxt_oe_n;
  logic busy_ff;
  logic c_we;
  logic [11:0] c_wa;
  logic [7:0] c_wd;
  logic [7:0] scan_b;
  logic [11:0] lane_code [0:3];
  logic [63:0] chk_vec;
  logic [11:0] diff;
  logic [10:0] pm1;
  logic [11:0] fa;

  // four bit lanes per codeword
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      nandec_lane u_lane (
        .clk(CLK),
        .rst(RST),
        .en(st_ff == nandec_pkg::S_SCAN),
        .clr(st_ff == nandec_pkg::S_SCAN && k_ff == 10'h000),
        .bit_lo(scan_b[g]),
        .bit_hi(scan_b[g+4]),
        .idx(k_ff),
        .code(lane_code[g])
      );
      assign chk_vec[12*g +: 12] = lane_code[g];
    end
  endgenerate
  assign chk_vec[63:48] = 16'h0000;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_ptr = ptr_ff;
    nxt_k = k_ff;
    nxt_j = j_ff;
    nxt_sec = sec_ff;
    nxt_lane = lane_ff;
    nxt_rd = rd_ff;
    nxt_mark = mark_ff;
    nxt_ecc_en = ecc_en_ff;
    nxt_ecc_st = ecc_st_ff;
    nxt_cor = cor_ff;
    nxt_unc = unc_ff;
    nxt_por_done = por_done_ff | ~pwr_ok;
    nxt_stored = stored_ff;
    nxt_wv = 1'b0;
    nxt_wd = wd_ff;
    c_we = 1'b0;
    c_wa = LOAD.addr;
    c_wd = LOAD.data;
    scan_b = cache[addr_of(sec_ff, k_ff)];
    diff = lane_code[lane_ff] ^ stored_ff[12*lane_ff +: 12];
    pm1 = 11'(diff[10:0] - 11'h001);
    fa = addr_of(sec_ff, pm1[10:1]);
    if (!pwr_ok) begin
      nxt_por_done = 1'b0;
    end
    if (FEAT.we && FEAT.addr == nandec_pkg::FEAT_ECC_ADDR &&
        st_ff == nandec_pkg::S_IDLE) begin
      nxt_ecc_en = FEAT.data[nandec_pkg::ECC_EN_BIT];
    end
    case (st_ff)
      nandec_pkg::S_IDLE: begin
        if (LOAD.we) begin
          c_we = 1'b1;
        end
        if (PROG_GO || MARK_GO) begin
          nxt_rd = 1'b0;
          nxt_mark = MARK_GO;
          nxt_sec = 2'h0;
          nxt_k = 10'h000;
          nxt_ptr = 12'h000;
          if (ecc_en_ff && !MARK_GO) begin
            nxt_st = nandec_pkg::S_SCAN;
          end else begin
            nxt_st = nandec_pkg::S_WRITE;
          end
        end else if (READ_GO) begin
          nxt_rd = 1'b1;
          nxt_ptr = 12'h000;
          nxt_ecc_st = nandec_pkg::ECC_NONE;
          nxt_cor = 1'b0;
          nxt_unc = 1'b0;
          nxt_st = nandec_pkg::S_LOAD;
        end
      end
      nandec_pkg::S_LOAD: begin
        if (ARR_RVALID) begin
          c_we = 1'b1;
          c_wa = ptr_ff;
          c_wd = ARR_RDATA;
          nxt_ptr = 12'(ptr_ff + 12'h001);
          if (ptr_ff == nandec_pkg::PAGE_LAST) begin
            nxt_sec = 2'h0;
            nxt_k = 10'h000;
            nxt_st = ecc_en_ff ? nandec_pkg::S_SCAN : nandec_pkg::S_IDLE;
          end
        end
      end
      nandec_pkg::S_SCAN: begin
        // one codeword: main area then its metadata
        nxt_k = 10'(k_ff + 10'h001);
        if (k_ff == nandec_pkg::SECT_LAST) begin
          nxt_j = 3'h0;
          nxt_st = nandec_pkg::S_CHK;
        end
      end
      nandec_pkg::S_CHK: begin
        c_wa = 12'(nandec_pkg::CHK_BASE + {6'h00, sec_ff, 4'h0} +
                   {9'h000, j_ff});
        if (rd_ff) begin
          nxt_stored[8*j_ff +: 8] = cache[c_wa];
        end else begin
          c_we = 1'b1;
          c_wd = chk_vec[8*j_ff +: 8];
        end
        nxt_j = 3'(j_ff + 3'h1);
        if (j_ff == nandec_pkg::CHK_LAST) begin
          nxt_k = 10'h000;
          nxt_lane = 2'h0;
          if (rd_ff) begin
            nxt_st = nandec_pkg::S_FIX;
          end else if (sec_ff == 2'h3) begin
            nxt_ptr = 12'h000;
            nxt_st = nandec_pkg::S_WRITE;
          end else begin
            nxt_sec = 2'(sec_ff + 2'h1);
            nxt_st = nandec_pkg::S_SCAN;
          end
        end
      end
      nandec_pkg::S_FIX: begin
        // one error per lane, four lanes per codeword
        if (diff[11]) begin
          if (diff[10:0] == 11'h000) begin
            nxt_cor = 1'b1;
          end else if (diff[10:0] <= nandec_pkg::POS_MAX) begin
            c_we = 1'b1;
            c_wa = fa;
            c_wd = cache[fa] ^ (8'h01 << {pm1[0], lane_ff});
            nxt_cor = 1'b1;
          end else begin
            nxt_unc = 1'b1;
          end
        end else if (diff[10:0] != 11'h000) begin
          nxt_unc = 1'b1;
        end
        nxt_lane = 2'(lane_ff + 2'h1);
        if (lane_ff == 2'h3) begin
          if (sec_ff == 2'h3) begin
            nxt_st = nandec_pkg::S_IDLE;
            nxt_ecc_st = nxt_unc ? nandec_pkg::ECC_FAIL :
                         nxt_cor ? nandec_pkg::ECC_FIXED :
                         nandec_pkg::ECC_NONE;
          end else begin
            nxt_sec = 2'(sec_ff + 2'h1);
            nxt_st = nandec_pkg::S_SCAN;
          end
        end
      end
      nandec_pkg::S_WRITE: begin
        nxt_wv = 1'b1;
        nxt_wd = mark_ff ? nandec_pkg::BAD_MARK : cache[ptr_ff];
        nxt_ptr = 12'(ptr_ff + 12'h001);
        if (ptr_ff == nandec_pkg::PAGE_LAST) begin
          nxt_st = nandec_pkg::S_IDLE;
        end
      end
      nandec_pkg::S_RST: begin
        nxt_cnt = cnt_ff - 32'h0000_0001;
        if (cnt_ff == 32'h0000_0001) begin
          nxt_st = nandec_pkg::S_IDLE;
        end
      end
      default: begin
        nxt_st = nandec_pkg::S_IDLE;
      end
    endcase
    if (RESET_GO || (wp_rise && pwr_ok && !por_done_ff)) begin
      nxt_st = nandec_pkg::S_RST;
      nxt_cnt = RST_CYCLES;
      nxt_por_done = 1'b1;
      nxt_ecc_st = nandec_pkg::ECC_NONE;
      nxt_wv = 1'b0;
      c_we = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (c_we) begin
      cache[c_wa] <= c_wd;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_ff <= nandec_pkg::S_IDLE;
      cnt_ff <= 32'h0000_0000;
      ptr_ff <= 12'h000;
      k_ff <= 10'h000;
      j_ff <= 3'h0;
      sec_ff <= 2'h0;
      lane_ff <= 2'h0;
      rd_ff <= 1'b0;
      mark_ff <= 1'b0;
      ecc_en_ff <= 1'b1;
      ecc_st_ff <= nandec_pkg::ECC_NONE;
      cor_ff <= 1'b0;
      unc_ff <= 1'b0;
      por_done_ff <= 1'b0;
      stored_ff <= 64'h0000_0000_0000_0000;
      wv_ff <= 1'b0;
      wd_ff <= 8'h00;
      busy_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      ptr_ff <= nxt_ptr;
      k_ff <= nxt_k;
      j_ff <= nxt_j;
      sec_ff <= nxt_sec;
      lane_ff <= nxt_lane;
      rd_ff <= nxt_rd;
      mark_ff <= nxt_mark;
      ecc_en_ff <= nxt_ecc_en;
      ecc_st_ff <= nxt_ecc_st;
      cor_ff <= nxt_cor;
      unc_ff <= nxt_unc;
      por_done_ff <= nxt_por_done;
      stored_ff <= nxt_stored;
      wv_ff <= nxt_wv;
      wd_ff <= nxt_wd;
      busy_ff <= nxt_st != nandec_pkg::S_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // feature read and serial output
  always_comb begin
    nxt_frd = frd_ff;
    if (FEAT.rd) begin
      nxt_frd = 8'h00;
      if (FEAT.addr == nandec_pkg::FEAT_STAT_ADDR) begin
        nxt_frd[nandec_pkg::STAT_ECC_LSB +: 2] = ecc_st_ff;
        nxt_frd[nandec_pkg::STAT_BUSY_BIT] = st_ff != nandec_pkg::S_IDLE;
      end else if (FEAT.addr == nandec_pkg::FEAT_ECC_ADDR) begin
        nxt_frd[nandec_pkg::ECC_EN_BIT] = ecc_en_ff;
      end
    end
    nxt_col = col_ff;
    nxt_sh = sh_ff;
    nxt_bc = bc_ff;
    // drive only when idle, after correction finished
    nxt_oe_n = ~(cs_low && st_ff == nandec_pkg::S_IDLE);
    if (SO_START && st_ff == nandec_pkg::S_IDLE) begin
      nxt_sh = cache[SO_COL];
      nxt_col = 12'(SO_COL + 12'h001);
      nxt_bc = 3'h0;
    end else if (sck_fall && !nxt_oe_n) begin
      nxt_bc = 3'(bc_ff + 3'h1);
      if (bc_ff == 3'h7) begin
        nxt_sh = cache[col_ff];
        nxt_col = 12'(col_ff + 12'h001);
      end else begin
        nxt_sh = {sh_ff[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      frd_ff <= 8'h00;
      col_ff <= 12'h000;
      sh_ff <= 8'h00;
      bc_ff <= 3'h0;
      oe_n_ff <= 1'b1;
    end else begin
      frd_ff <= nxt_frd;
      col_ff <= nxt_col;
      sh_ff <= nxt_sh;
      bc_ff <= nxt_bc;
      oe_n_ff <= nxt_oe_n;
    end
  end

  assign ARR_WVALID = wv_ff;
  assign ARR_WDATA = wd_ff;
  assign FEAT_RDATA = frd_ff;
  assign BUSY = busy_ff;
  assign ECC_EN = ecc_en_ff;
  assign SO = sh_ff[7];
  assign SO_OE_N = oe_n_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_ecc_write;
    FEAT.we && FEAT.addr == nandec_pkg::FEAT_ECC_ADDR &&
    st_ff == nandec_pkg::S_IDLE && !RESET_GO;
  endsequence
  property p_feat_ecc;
    @(posedge CLK) disable iff (RST)
    s_ecc_write |=> ecc_en_ff == $past(FEAT.data[nandec_pkg::ECC_EN_BIT]);
  endproperty
  a_feat_ecc: assert property (p_feat_ecc)
    else $error("ecc enable lost");
  property p_rst_ecc_on;
    @(posedge CLK) RST |=> ecc_en_ff && ecc_st_ff == nandec_pkg::ECC_NONE;
  endproperty
  a_rst_ecc_on: assert property (p_rst_ecc_on)
    else $error("reset state wrong");
  property p_scan_first;
    @(posedge CLK) disable iff (RST)
    (st_ff == nandec_pkg::S_WRITE && $past(st_ff) == nandec_pkg::S_IDLE)
    |-> !$past(ecc_en_ff) || $past(MARK_GO);
  endproperty
  a_scan_first: assert property (p_scan_first)
    else $error("write skipped ecc");
  property p_chk_place;
    @(posedge CLK) disable iff (RST)
    (st_ff == nandec_pkg::S_CHK && !rd_ff && !RESET_GO) |->
    c_we && c_wa[3] && c_wa[11:6] == nandec_pkg::CHK_BASE[11:6];
  endproperty
  a_chk_place: assert property (p_chk_place)
    else $error("check byte misplaced");
  property p_no_out_busy;
    @(posedge CLK) disable iff (RST)
    st_ff != nandec_pkg::S_IDLE |=> SO_OE_N;
  endproperty
  a_no_out_busy: assert property (p_no_out_busy)
    else $error("output while busy");
  property p_code_legal;
    @(posedge CLK) disable iff (RST) ecc_st_ff != 2'h3;
  endproperty
  a_code_legal: assert property (p_code_legal)
    else $error("reserved code");
  property p_read_clear;
    @(posedge CLK) disable iff (RST)
    (READ_GO && st_ff == nandec_pkg::S_IDLE && !PROG_GO && !MARK_GO)
    |=> ecc_st_ff == nandec_pkg::ECC_NONE;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status not cleared");
  property p_mark_zero;
    @(posedge CLK) disable iff (RST)
    (wv_ff && mark_ff) |-> wd_ff == nandec_pkg::BAD_MARK;
  endproperty
  a_mark_zero: assert property (p_mark_zero)
    else $error("bad mark not zero");
  sequence s_auto_rst;
    wp_rise && pwr_ok && !por_done_ff;
  endsequence
  property p_auto_rst;
    @(posedge CLK) disable iff (RST)
    s_auto_rst |=> st_ff == nandec_pkg::S_RST ##1 BUSY;
  endproperty
  a_auto_rst: assert property (p_auto_rst)
    else $error("no auto reset");
endmodule

/* File: verif/nandec_host_model.sv */
`timescale 1ns/1ps
module nandec_host_model (
  output logic SCK,
  output logic CS_N,
  input wire logic SO,
  input wire logic SO_OE_N
);
  logic [7:0] rx [0:3];
  logic oe_ok;
  initial begin
    SCK = 1'b0;
    CS_N = 1'b1;
    oe_ok = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // one read frame, clock runs only while selected
  task automatic frame(input int n);
    oe_ok = 1'b1;
    CS_N = 1'b0;
    #300;
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        rx[b][i] = SO;
        if (SO_OE_N !== 1'b0) begin
          oe_ok = 1'b0;
        end
        SCK = 1'b1;
        #100;
        SCK = 1'b0;
        #100;
      end
    end
    CS_N = 1'b1;
  endtask
endmodule

/* File: verif/nandec_top_tb.sv */
`timescale 1ns/1ps
module nandec_top_tb;
  localparam int RC = 20;
  logic clk, rst, pwr_ok, wp_n, sck, cs_n, reset_go, prog_go, read_go;
  logic mark_go, so_start, arr_rvalid, arr_wvalid, busy, ecc_en, so, so_oe_n;
  logic [11:0] so_col;
  logic [7:0] arr_rdata, arr_wdata, feat_rdata;
  nandec_pkg::nandec_feat_t feat;
  nandec_pkg::nandec_load_t load;
  logic [7:0] page [0:2111];
  logic [7:0] arr [0:2111];
  logic [7:0] err [0:2111];
  logic [1:0] codes [0:3];
  int fail_count = 0;
  int num_checks = 0;
  int k;

  nandec_top #(.RST_CYCLES(RC)) i_nandec_top (
    .CLK(clk), .RST(rst), .PWR_OK(pwr_ok), .WP_N(wp_n), .SCK(sck),
    .CS_N(cs_n), .RESET_GO(reset_go), .PROG_GO(prog_go),
    .READ_GO(read_go), .MARK_GO(mark_go), .SO_START(so_start),
    .SO_COL(so_col), .FEAT(feat), .LOAD(load), .ARR_RVALID(arr_rvalid),
    .ARR_RDATA(arr_rdata), .ARR_WVALID(arr_wvalid), .ARR_WDATA(arr_wdata),
    .FEAT_RDATA(feat_rdata), .BUSY(busy), .ECC_EN(ecc_en), .SO(so),
    .SO_OE_N(so_oe_n)
  );
  nandec_host_model i_nandec_host_model (
    .SCK(sck), .CS_N(cs_n), .SO(so), .SO_OE_N(so_oe_n)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_idle(input int lim);
    int w;
    w = 0;
    while (busy !== 1'b0 && w < lim) begin
      tick();
      w++;
    end
    if (w >= lim) begin
      fail_count++;
      $display("CHECK FAILED t=%0t busy timeout", $time);
      close_out();
    end
  endtask
  function automatic logic [7:0] st_exp(input logic [1:0] c, input logic b);
    return {2'b00, c, 3'b000, b};
  endfunction
  task automatic feat_op(input logic w, input logic [7:0] a,
                         input logic [7:0] d);
    feat = '{we: w, rd: !w, addr: a, data: d};
    tick();
    feat = '0;
    tick();
  endtask
  ////////////////////////////////////////////////////////////////////////
  // whole page into cache, check bytes skipped while correcting
  task automatic load_page(input logic ecc);
    for (int i = 0; i < 2112; i++) begin
      if (!(ecc && i >= 12'h800 && i[3])) begin
        load = '{we: 1'b1, addr: 12'(i), data: page[i]};
        tick();
      end
    end
    load = '0;
  endtask
  // one program per page, collected into the array image
  task automatic write_out(input logic mark, input logic ecc);
    int n;
    n = 0;
    k = 0;
    mark_go = mark;
    prog_go = !mark;
    tick();
    mark_go = 1'b0;
    prog_go = 1'b0;
    if (ecc) begin
      feat_op(1'b1, nandec_pkg::FEAT_ECC_ADDR, 8'h00);
      chk({7'b0, ecc_en}, 8'h01);
    end
    while (n < 2112 && k < 8000) begin
      if (arr_wvalid === 1'b1) begin
        arr[n] = arr_wdata;
        n++;
      end
      tick();
      k++;
    end
    chk({7'b0, n == 2112}, 8'h01);
    wait_idle(50);
  endtask
  task automatic read_in(input logic [1:0] code, input logic ecc);
    logic g;
    int i;
    read_go = 1'b1;
    tick();
    read_go = 1'b0;
    feat_op(1'b0, nandec_pkg::FEAT_STAT_ADDR, 8'h00);
    chk(feat_rdata, st_exp(2'b00, 1'b1));
    i = 0;
    while (i < 2112) begin
      g = ($urandom_range(3) != 0);
      arr_rvalid = g;
      arr_rdata = arr[i] ^ err[i];
      tick();
      if (g) begin
        i++;
      end
    end
    arr_rvalid = 1'b0;
    wait_idle(3000);
    if (ecc) begin
      feat_op(1'b0, nandec_pkg::FEAT_STAT_ADDR, 8'h00);
      chk(feat_rdata, st_exp(code, 1'b0));
    end
  endtask
  task automatic ser(input logic [11:0] col, input logic [7:0] x);
    so_col = col;
    so_start = 1'b1;
    tick();
    so_start = 1'b0;
    tick();
    i_nandec_host_model.frame(2);
    tick(6);
    chk(i_nandec_host_model.rx[0], page[col] ^ x);
    chk(i_nandec_host_model.rx[1], page[col + 1]);
    chk({i_nandec_host_model.oe_ok, so_oe_n}, 8'h03);
  endtask
  task automatic set_err(input int c);
    foreach (err[i]) err[i] = 8'h00;
    case (c)
      1: begin
        for (int s = 0; s < 4; s++) begin
          for (int l = 0; l <= s; l++) begin
            err[s * 512 + 7 * l] = 8'h01 << (l + 4 * (l % 2));
          end
        end
      end
      2: err[12'h809] = 8'h08;
      3: begin
        err[12'h400] = 8'h01;
        err[12'h401] = 8'h10;
      end
      default: ;
    endcase
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1; pwr_ok = 1'b0; wp_n = 1'b0; reset_go = 1'b0;
    prog_go = 1'b0; read_go = 1'b0; mark_go = 1'b0; so_start = 1'b0;
    so_col = '0; feat = '0; load = '0; arr_rvalid = 1'b0; arr_rdata = '0;
    codes = '{2'b00, 2'b01, 2'b01, 2'b10};
    void'($urandom(6061));
    tick(8);
    rst = 1'b0;
    tick(3);
    chk({7'b0, ecc_en}, 8'h01);
    feat_op(1'b0, nandec_pkg::FEAT_STAT_ADDR, 8'h00);
    chk(feat_rdata, st_exp(2'b00, 1'b0));
    // power-up without reset command
    pwr_ok = 1'b1;
    tick(10000);
    wp_n = 1'b1;
    tick(5);
    chk({7'b0, busy}, 8'h01);
    wait_idle(RC + 10);
    reset_go = 1'b1;
    tick();
    reset_go = 1'b0;
    k = 0;
    while (busy === 1'b1 && k < 100) begin
      tick();
      k++;
    end
    chk({7'b0, k >= RC - 2 && k <= RC + 1}, 8'h01);
    for (int v = 0; v < 2; v++) begin
      feat_op(1'b1, nandec_pkg::FEAT_ECC_ADDR, v ? 8'h10 : 8'h00);
      feat_op(1'b0, nandec_pkg::FEAT_ECC_ADDR, 8'h00);
      chk(feat_rdata, v ? 8'h10 : 8'h00);
      chk({7'b0, ecc_en}, 8'(v));
    end
    feat_op(1'b0, 8'hA0, 8'h00);
    chk(feat_rdata, 8'h00);
    // correcting program and reads
    foreach (page[i]) page[i] = 8'($urandom);
    load_page(1'b1);
    write_out(1'b0, 1'b1);
    foreach (arr[i]) if (!(i >= 12'h800 && i[3])) chk(arr[i], page[i]);
    chk(arr[12'h80E], 8'h00);
    for (int c = 0; c < 4; c++) begin
      set_err(c);
      read_in(codes[c], 1'b1);
      ser(12'h200, 8'h00);
    end
    // correction off: raw data passes
    feat_op(1'b1, nandec_pkg::FEAT_ECC_ADDR, 8'h00);
    load_page(1'b0);
    write_out(1'b0, 1'b0);
    chk(arr[12'h808], page[12'h808]);
    set_err(1);
    read_in(2'b00, 1'b0);
    ser(12'h200, 8'h01);
    // bad-block page
    write_out(1'b1, 1'b0);
    foreach (arr[i]) chk(arr[i], nandec_pkg::BAD_MARK);
    set_err(0);
    read_in(2'b00, 1'b0);
    foreach (page[i]) page[i] = 8'h00;
    ser(nandec_pkg::BAD_MARK_ADDR, 8'h00);
    close_out();
  end
endmodule
